// ===== design/scrg_pkg.sv
// package for the serial checksum / ready / pin-direction register bank
// assumes an internal register port driven by the serial host interface logic
package scrg_pkg;
	localparam logic [6:0] ADDR_PIN_DIRECTION = 7'h0E;
	localparam logic [6:0] ADDR_READY_CTRL = 7'h11;
	localparam logic [6:0] ADDR_CHECKSUM_CTRL = 7'h13;
	localparam logic [6:0] ADDR_CHECKSUM_VALUE = 7'h1D;
	localparam logic [6:0] ADDR_CONV_LOW = 7'h1B;
	localparam int READY_PIN_SIX_BIT = 7;
	localparam int READY_NO_CLEAR_BIT = 5;
	localparam int READY_GAIN_CAL_BIT = 3;
	localparam int CKS_ENABLE_BIT = 4;
	localparam int CKS_AFTER_CHECKSUM_BIT = 2;
	localparam logic [7:0] READY_CTRL_RESET = 8'h03;
	localparam logic [7:0] READY_CTRL_MASK = 8'hAF;
	localparam logic [7:0] CKS_CTRL_RESET = 8'h00;
	localparam logic [7:0] CKS_CTRL_MASK = 8'h14;
	localparam logic [7:0] PIN_DIR_RESET = 8'h00;
	localparam logic [7:0] PIN_DIR_MASK = 8'h7F;
	localparam logic [7:0] CKS_POLY_DEFAULT = 8'h07;
	localparam logic [7:0] CKS_SEED = 8'h00;
	typedef struct packed {
		logic wrEn;
		logic rdEn;
		logic [6:0] addr;
		logic [7:0] wrData;
	} scrg_req_type;
	typedef struct packed {
		logic [6:0] oe;
		logic [6:0] out;
	} scrg_pins_type;
endpackage : scrg_pkg

// ===== design/scrg_regbank.sv
// register bank: ready routing, checksum control and value, pin direction
// assumes req/rdData on sys_clk from the serial port logic; pins in are asynchronous
`timescale 1ns/10ps
`default_nettype none
// Operation
// R01: ready-control bit 7 routes active-low data-ready onto general pin six.
// R02: ready-control bit 5 clear makes ready release clear the checksum.
// R03: ready-control bit 3 picks live or last-known gain calibration coefficients.
// R04: host keeps ready-control bits 2..0 at three when writing.
// R05: checksum-control bit 4 enables checksum generation over readback bytes.
// R06: host keeps checksum-control bit 3 at zero when writing.
// R07: checksum-control bit 2 moves ready release after the checksum byte read.
// R08: any write to checksum-value register resets the checksum accumulator.
// R09: reading checksum-value register returns current eight-bit checksum.
// R10: pin-direction bit x makes general pin x output when one.
// R11: while pin six carries data-ready its general-purpose settings are ignored.
// R12: reserved bits read zero, ignore writes; polynomial is a parameter. Ready-control bits 2..0 keep the written value and read back.
module scrg_regbank import scrg_pkg::*; #(
	parameter logic [7:0] CKS_POLY = CKS_POLY_DEFAULT
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire scrg_req_type req,
	input wire logic dataReady,
	input wire logic [6:0] pinDataOut,
	input wire logic [6:0] pinIn,
	output logic [7:0] rdData,
	output logic readyN,
	output logic [6:0] pinOut,
	output logic [6:0] pinOeN,
	output logic [6:0] pinInSync,
	output logic gainCalCoeffSel,
	output logic checksumEnable
);

	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] cks_step(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ((r << 1) ^ CKS_POLY) : (r << 1);
		end
		return r;
	endfunction : cks_step

	logic [7:0] readyCtrl_q, readyCtrl_d, cksCtrl_q, cksCtrl_d, pinDir_q, pinDir_d;
	logic [7:0] checksum_q, checksum_d, rdData_q, rdData_d;
	logic readyN_q, readyN_d, pending_q, pending_d, readyDly_q;
	logic [6:0] pinOut_q, pinOut_d, pinOeN_q, pinOeN_d, sync1_q, sync2_q;
	logic readyPin6, readyRelease;
	logic isLowRd, isCksRd;

	assign readyPin6 = readyCtrl_q[READY_PIN_SIX_BIT];
	assign isLowRd = req.rdEn && req.addr == ADDR_CONV_LOW;
	assign isCksRd = req.rdEn && req.addr == ADDR_CHECKSUM_VALUE;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		readyCtrl_d = readyCtrl_q;
		cksCtrl_d = cksCtrl_q;
		pinDir_d = pinDir_q;
		if (req.wrEn) begin
			case (req.addr)
				// reserved low field keeps whatever the host writes, host keeps it at three
				ADDR_READY_CTRL: readyCtrl_d = req.wrData & (READY_CTRL_MASK | 8'h07); // R04
				ADDR_CHECKSUM_CTRL: cksCtrl_d = req.wrData & CKS_CTRL_MASK; // R06
				ADDR_PIN_DIRECTION: pinDir_d = req.wrData & PIN_DIR_MASK; // R12
				default: ;
			endcase
		end
	end

	// release: low byte read, or with the after-checksum option set, a checksum read that follows a low byte read
	// a fresh conversion edge beats a release in the same cycle, so no result is dropped
	always_comb begin
		pending_d = pending_q;
		readyN_d = readyN_q;
		readyRelease = 1'b0;
		if (dataReady && !readyDly_q) begin
			readyN_d = 1'b0;
			pending_d = 1'b0;
		end else if (!readyN_q) begin
			if (cksCtrl_q[CKS_AFTER_CHECKSUM_BIT]) begin // R07
				if (isLowRd) pending_d = 1'b1;
				if (pending_q && isCksRd) begin
					readyRelease = 1'b1;
					readyN_d = 1'b1;
					pending_d = 1'b0;
				end
			end else if (isLowRd) begin
				readyRelease = 1'b1;
				readyN_d = 1'b1;
			end
		end
	end

	always_comb begin
		checksum_d = checksum_q;
		// the readback byte is folded in as it leaves, the clears win over it
		if (cksCtrl_q[CKS_ENABLE_BIT] && req.rdEn && !isCksRd) begin // R05
			checksum_d = cks_step(checksum_q, rdData_d);
		end
		if (readyRelease && !readyCtrl_q[READY_NO_CLEAR_BIT]) checksum_d = CKS_SEED; // R02
		if (req.wrEn && req.addr == ADDR_CHECKSUM_VALUE) checksum_d = CKS_SEED; // R08
	end

	always_comb begin
		case (req.addr)
			ADDR_READY_CTRL: rdData_d = readyCtrl_q;
			ADDR_CHECKSUM_CTRL: rdData_d = cksCtrl_q;
			ADDR_PIN_DIRECTION: rdData_d = pinDir_q;
			ADDR_CHECKSUM_VALUE: rdData_d = checksum_q; // R09
			default: rdData_d = 8'h00; // R12
		endcase
		if (!req.rdEn) rdData_d = rdData_q;
	end

	always_comb begin
		pinOut_d = pinDataOut;
		pinOeN_d = ~pinDir_q[6:0]; // R10
		if (readyPin6) begin // R01
			pinOut_d[6] = readyN_d;
			pinOeN_d[6] = 1'b0; // R11
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			readyCtrl_q <= READY_CTRL_RESET;
			cksCtrl_q <= CKS_CTRL_RESET;
			pinDir_q <= PIN_DIR_RESET;
			checksum_q <= CKS_SEED;
			rdData_q <= 8'h00;
			readyN_q <= 1'b1;
			pending_q <= 1'b0;
			readyDly_q <= 1'b0;
			pinOut_q <= 7'h00;
			pinOeN_q <= 7'h7F;
			sync1_q <= 7'h00;
			sync2_q <= 7'h00;
		end else begin
			readyCtrl_q <= readyCtrl_d;
			cksCtrl_q <= cksCtrl_d;
			pinDir_q <= pinDir_d;
			checksum_q <= checksum_d;
			rdData_q <= rdData_d;
			readyN_q <= readyN_d;
			pending_q <= pending_d;
			readyDly_q <= dataReady;
			pinOut_q <= pinOut_d;
			pinOeN_q <= pinOeN_d;
			sync1_q <= pinIn;
			sync2_q <= sync1_q;
		end
	end

	assign rdData = rdData_q;
	assign readyN = readyN_q;
	assign pinOut = pinOut_q;
	assign pinOeN = pinOeN_q;
	assign pinInSync = sync2_q;
	assign gainCalCoeffSel = readyCtrl_q[READY_GAIN_CAL_BIT]; // R03
	assign checksumEnable = cksCtrl_q[CKS_ENABLE_BIT];

	////////////////////////////////////////////////////////////////////////
	// pin-side checks; each watches only what the bank drives
	a_pin6_ready_route: assert property (@(posedge sys_clk) disable iff (!rstn) // R01
		readyPin6 |=> pinOut[6] == readyN && !pinOeN[6])
		else $error("pin six not carrying ready");
	a_pin6_gpio_route: assert property (@(posedge sys_clk) disable iff (!rstn) // R11
		!readyPin6 |=> pinOeN[6] == !$past(pinDir_q[6]))
		else $error("pin six direction wrong");
	a_pin6_gpio_data: assert property (@(posedge sys_clk) disable iff (!rstn) // R11
		!readyPin6 |=> pinOut[6] == $past(pinDataOut[6]))
		else $error("pin six data wrong");
	a_pin_data_out: assert property (@(posedge sys_clk) disable iff (!rstn) // R10
		1'b1 |=> pinOut[5:0] == $past(pinDataOut[5:0]))
		else $error("pin data not passed");
	a_dir_outputs: assert property (@(posedge sys_clk) disable iff (!rstn) // R10
		req.wrEn && req.addr == ADDR_PIN_DIRECTION
		|=> ##1 pinOeN[5:0] == ~$past(req.wrData[5:0], 2))
		else $error("direction not applied");

	// checksum checks; the clears are allowed to override a fold in the same cycle
	a_clear_on_release: assert property (@(posedge sys_clk) disable iff (!rstn) // R02
		readyRelease && !readyCtrl_q[READY_NO_CLEAR_BIT] |=> checksum_q == CKS_SEED)
		else $error("checksum not cleared on release");
	a_cks_write_reset: assert property (@(posedge sys_clk) disable iff (!rstn) // R08
		req.wrEn && req.addr == ADDR_CHECKSUM_VALUE |=> checksum_q == CKS_SEED)
		else $error("checksum write did not reset");
	a_cks_readback: assert property (@(posedge sys_clk) disable iff (!rstn) // R09
		isCksRd |=> rdData == $past(checksum_q))
		else $error("checksum read wrong");
	a_cks_disabled: assert property (@(posedge sys_clk) disable iff (!rstn) // R05
		!cksCtrl_q[CKS_ENABLE_BIT] && !req.wrEn && !readyRelease |=> $stable(checksum_q))
		else $error("checksum moved while disabled");
	a_cks_fold: assert property (@(posedge sys_clk) disable iff (!rstn) // R05
		cksCtrl_q[CKS_ENABLE_BIT] && req.rdEn && !isCksRd && !readyRelease
		|=> checksum_q == cks_step($past(checksum_q), rdData))
		else $error("readback byte not folded");
	a_cks_enable_out: assert property (@(posedge sys_clk) disable iff (!rstn) // R05
		req.wrEn && req.addr == ADDR_CHECKSUM_CTRL
		|=> checksumEnable == $past(req.wrData[CKS_ENABLE_BIT]))
		else $error("checksum enable output wrong");

	// ready checks
	a_ready_assert: assert property (@(posedge sys_clk) disable iff (!rstn) // R01
		dataReady && !readyDly_q |=> !readyN)
		else $error("ready not asserted on conversion");
	a_release_low: assert property (@(posedge sys_clk) disable iff (!rstn) // R07
		!readyN && !cksCtrl_q[CKS_AFTER_CHECKSUM_BIT] && isLowRd && !(dataReady && !readyDly_q)
		|=> readyN)
		else $error("ready not released on low byte");
	a_hold_until_cks: assert property (@(posedge sys_clk) disable iff (!rstn) // R07
		!readyN && cksCtrl_q[CKS_AFTER_CHECKSUM_BIT] && !isCksRd |=> !readyN)
		else $error("ready released early");
	a_gain_cal_sel: assert property (@(posedge sys_clk) disable iff (!rstn) // R03
		req.wrEn && req.addr == ADDR_READY_CTRL
		|=> gainCalCoeffSel == $past(req.wrData[READY_GAIN_CAL_BIT]))
		else $error("gain cal select wrong");

	// readback of reserved and unmapped locations
	a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rstn) // R12
		req.rdEn && req.addr == ADDR_CHECKSUM_CTRL
		|=> rdData[7:5] == 3'h0 && rdData[1:0] == 2'h0)
		else $error("reserved bits nonzero");
	a_ready_reserved: assert property (@(posedge sys_clk) disable iff (!rstn) // R12
		req.rdEn && req.addr == ADDR_READY_CTRL |=> rdData[6] == 1'b0 && rdData[4] == 1'b0)
		else $error("ready control reserved bits nonzero");
	a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (!rstn) // R12
		req.rdEn && req.addr > ADDR_CHECKSUM_VALUE |=> rdData == 8'h00)
		else $error("unmapped read not zero");

endmodule : scrg_regbank
`default_nettype wire

// ===== sim/scrg_host_model.sv
// host side model: turns bench commands into register requests
// assumes the bench changes commands just after a rising sys_clk edge
`timescale 1ns/10ps
`default_nettype none
module scrg_host_model import scrg_pkg::*; (
	input wire logic cmdWr,
	input wire logic cmdRd,
	input wire logic [6:0] cmdAddr,
	input wire logic [7:0] cmdData,
	output var scrg_req_type req
);
	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		req.wrEn = cmdWr;
		req.rdEn = cmdRd;
		req.addr = cmdAddr;
		// idle write data is scrambled so a stale byte is never mistaken for a write
		req.wrData = cmdWr ? cmdData : ~cmdData;
		if (cmdWr && cmdAddr == ADDR_READY_CTRL) req.wrData[2:0] = 3'h3;
		if (cmdWr && cmdAddr == ADDR_CHECKSUM_CTRL) req.wrData[3] = 1'b0;
	end
endmodule : scrg_host_model
`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench for the register bank
// assumes a single 25 MHz clock and the host model on the request port
`timescale 1ns/10ps
`default_nettype none
module tb_top import scrg_pkg::*;;
	typedef struct packed {logic [6:0] a; logic [7:0] d; logic [7:0] e;} scrg_row_type;
	logic sys_clk = 0, rstn = 0, cWr = 0, cRd = 0, dataReady = 0, gcs, cen, readyN;
	logic [6:0] cA = 0, pinDataOut = 7'h55, pinIn = 7'h2A, pinOut, pinOeN, pinInSync;
	logic [7:0] cD = 0, rdData, rdv, exp;
	scrg_req_type req;
	int miscompares = 0, compares = 0;
	scrg_row_type rows [4] = '{'{7'h0E, 8'hFF, 8'h7F}, '{7'h11, 8'hFF, 8'hAB},
		'{7'h13, 8'hFF, 8'h14}, '{7'h20, 8'hFF, 8'h00}};
	scrg_host_model u_host (.cmdWr(cWr), .cmdRd(cRd), .cmdAddr(cA), .cmdData(cD), .req(req));
	scrg_regbank u_dut (.sys_clk(sys_clk), .rstn(rstn), .req(req), .dataReady(dataReady),
		.pinDataOut(pinDataOut), .pinIn(pinIn), .rdData(rdData), .readyN(readyN),
		.pinOut(pinOut), .pinOeN(pinOeN), .pinInSync(pinInSync), .gainCalCoeffSel(gcs),
		.checksumEnable(cen));
	////////////////////////////////////////////////////////////////////////////
	initial forever #20 sys_clk = ~sys_clk;
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] x;
		x = c ^ b;
		for (int i = 0; i < 8; i++) x = x[7] ? ((x << 1) ^ CKS_POLY_DEFAULT) : (x << 1);
		return x;
	endfunction : crc8
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		cWr <= w;
		cRd <= !w;
		cA <= a;
		cD <= d;
		@(posedge sys_clk);
		cWr <= 0;
		cRd <= 0;
		repeat (2) @(posedge sys_clk);
		#1 rdv = rdData;
	endtask : acc
	task automatic pulse;
		@(posedge sys_clk);
		dataReady <= 1;
		@(posedge sys_clk);
		dataReady <= 0;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask : pulse
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : complete_run
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5000) @(posedge sys_clk);
		miscompares++;
		complete_run();
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		rstn <= 1;
		chk("readyN", {7'h0, readyN}, 8'h01);
		chk("oe", {1'b0, pinOeN}, 8'h7F);
		acc(0, ADDR_READY_CTRL, 0);
		chk("rdy", rdv, READY_CTRL_RESET);
		acc(0, ADDR_CHECKSUM_CTRL, 0);
		chk("cks", rdv, CKS_CTRL_RESET);
		foreach (rows[i]) begin
			acc(1, rows[i].a, rows[i].d);
			acc(0, rows[i].a, 0);
			chk("row", rdv, rows[i].e);
		end
		chk("gcs", {7'h0, gcs}, 8'h01);
		chk("cen", {7'h0, cen}, 8'h01);
		chk("oe6", {1'b0, pinOeN}, 8'h00);
		chk("out", {1'b0, pinOut}, 8'h55);
		chk("sync", {1'b0, pinInSync}, 8'h2A);
		acc(1, ADDR_CHECKSUM_VALUE, 8'h5A);
		acc(0, ADDR_CHECKSUM_VALUE, 0);
		chk("clr", rdv, 8'h00);
		pulse();
		chk("pin6", {7'h0, pinOut[6]}, 8'h00);
		acc(0, ADDR_READY_CTRL, 0);
		acc(0, ADDR_CONV_LOW, 0);
		exp = crc8(crc8(CKS_SEED, 8'hAB), 8'h00);
		chk("hold", {7'h0, readyN}, 8'h00);
		acc(0, ADDR_CHECKSUM_VALUE, 0);
		chk("crc", rdv, exp);
		chk("rel", {7'h0, readyN}, 8'h01);
		acc(0, ADDR_CHECKSUM_VALUE, 0);
		chk("keep", rdv, exp);
		acc(1, ADDR_READY_CTRL, 8'h03);
		acc(1, ADDR_CHECKSUM_CTRL, 8'h10);
		chk("gpio6", {1'b0, pinOeN}, 8'h00);
		pulse();
		acc(0, ADDR_CONV_LOW, 0);
		chk("rel0", {7'h0, readyN}, 8'h01);
		acc(0, ADDR_CHECKSUM_VALUE, 0);
		chk("rclr", rdv, 8'h00);
		acc(1, ADDR_PIN_DIRECTION, 8'h00);
		chk("in", {1'b0, pinOeN}, 8'h7F);
		rstn <= 0;
		repeat (2) @(posedge sys_clk);
		chk("rstcen", {7'h0, cen}, 8'h00);
		rstn <= 1;
		acc(0, ADDR_CHECKSUM_CTRL, 0);
		chk("rst2", rdv, CKS_CTRL_RESET);
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
